// File: core/fp_coprocessor_opcode_dispatch.v
// Overview of operation
// - Three specifiers; only opcode-needed operands used.
// - Non-NOP unused specifiers still read or written.
// - Unassigned opcodes behave exactly like no-operation.
// - Memory sources widened to extended format first.
// - Single or double destination narrowed, then rounded.
// - Fault result goes to fault data, else destination.
// - Add, subtract, divide, remainder, multiply opcodes.
// - Absolute, square root, round-integral, negate opcodes.
// - Four compare opcodes, plain and swapped.
// - Move, status read/write, fault data load opcodes.
// - Four conversion opcodes between float, integer, decimal.
// - Extract-fault-result and no-operation opcodes.
// - Invalid: sticky, then trap, software NaN, quiet NaN.
// - Invalid fault clears Z, keeps N.
// - Fault data gets trapping first, else second.
// - Float-to-integer/decimal register destination saves source.
// - Integer/decimal-to-float register source leaves data unspecified.
// - Divide-by-zero: sticky, trap or signed infinity.
// - Action passes first operand as result.
// - Action returns zero with normal sign.
// - Action returns infinity with normal sign.
// - Sign-dependent zero follows signs and rounding mode.
// - Narrowing rounds; may flag overflow or underflow.
// - Action passes second operand as result.
`timescale 1ns/10ps
`include "fp_dispatch_defs.vh"
module fp_coprocessor_opcode_dispatch (
   // Clock and reset.
   input wire aclk,
   input wire aresetn,
   // Write address and data channels.
   input wire [7:0] awaddr,
   input wire awvalid,
   output reg awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output reg wready,
   // Write response channel.
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   // Read channels.
   input wire [7:0] araddr,
   input wire arvalid,
   output reg arready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   // Command completion towards the host.
   output reg done_pulse,
   output reg exception_signal
);
   // -----------------------------------------------------------
   // Sequencer states
   // -----------------------------------------------------------
   localparam S_IDLE = 3'h0;
   localparam S_FETCH1 = 3'h1;
   localparam S_FETCH2 = 3'h2;
   localparam S_CONV = 3'h3;
   localparam S_EXEC = 3'h4;
   localparam S_NARROW = 3'h5;
   localparam S_ROUND = 3'h6;
   localparam S_STORE = 3'h7;

   reg [2:0] state_reg;
   reg [31:0] cmd_reg;
   reg [31:0] auxiliary_status_reg;
   reg [31:0] op1_mem_reg;
   reg [31:0] op2_mem_reg;
   reg [31:0] action_reg;
   reg [31:0] dp_result_reg;
   reg [31:0] result_mem_reg;
   reg [31:0] fault_data_register;
   reg [31:0] first_operand;
   reg [31:0] second_operand;
   reg [31:0] result_operand;
   reg [31:0] fpr [0:3];
   reg wide1_reg;
   reg wide2_reg;
   reg narrow_reg;
   reg fault_reg;
   reg done_reg;
   reg aw_full;
   reg w_full;
   reg [7:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;

   wire [7:0] opcode = cmd_reg[7:0];
   wire [7:0] spec1 = cmd_reg[15:8];
   wire [7:0] spec2 = cmd_reg[23:16];
   wire [7:0] spec3 = cmd_reg[31:24];
   wire [1:0] rounding_control_field = auxiliary_status_reg[`ASR_RC_HI:`ASR_RC_LO];
   wire round_toward_minus = (rounding_control_field == `RC_MINUS);
   wire [3:0] act_code = action_reg[`ACT_CODE_HI:0];
   wire act_sign = action_reg[`ACT_SIGN];
   wire busy = (state_reg != S_IDLE);

   // -----------------------------------------------------------
   // Opcode decode
   // -----------------------------------------------------------
   reg is_arith;
   reg is_cmp;
   reg cmp_swap;
   reg is_f2x;
   reg is_x2f;
   always @* begin
      is_arith = 1'b0;
      is_cmp = 1'b0;
      cmp_swap = 1'b0;
      is_f2x = 1'b0;
      is_x2f = 1'b0;
      case (opcode)
         `OPC_ADD, `OPC_SUB, `OPC_DIV, `OPC_REM, `OPC_MUL: is_arith = 1'b1;
         `OPC_ABS, `OPC_SQUARE_ROOT_OP, `OPC_RINT, `OPC_NEG, `OPC_MOVE: is_arith = 1'b1;
         `OPC_CMP, `OPC_CMPX: is_cmp = 1'b1;
         `OPC_COMPARE_SWAPPED_OP, `OPC_CMPXS: begin
            is_cmp = 1'b1;
            cmp_swap = 1'b1;
         end
         `OPC_F2I, `OPC_F2D: begin
            is_arith = 1'b1;
            is_f2x = 1'b1;
         end
         `OPC_I2F, `OPC_D2F: begin
            is_arith = 1'b1;
            is_x2f = 1'b1;
         end
         default: is_arith = 1'b0;
      endcase
   end

   // -----------------------------------------------------------
   // Special-case action and result selection
   // -----------------------------------------------------------
   reg [31:0] ex_res;
   reg ex_fault;
   reg ex_setnz;
   reg ex_is;
   reg ex_qs;
   reg ex_dr_we;
   reg [31:0] ex_dr;
   reg ex_j;
   always @* begin
      ex_res = first_operand;
      ex_fault = 1'b0;
      ex_setnz = 1'b0;
      ex_is = 1'b0;
      ex_qs = 1'b0;
      ex_dr_we = 1'b0;
      ex_dr = second_operand;
      ex_j = 1'b0;
      if (opcode == `OPC_RDSTAT) begin
         ex_res = auxiliary_status_reg;
      end else if (opcode == `OPC_EXTR) begin
         ex_res = fault_data_register;
      end else if (is_arith || is_cmp) begin
         ex_setnz = is_arith;
         case (act_code)
            `ACT_INVALID: begin
               ex_is = 1'b1;
               if (auxiliary_status_reg[`ASR_IM] ||
                   auxiliary_status_reg[`ASR_NONTRAPPING_NAN_CONTROL]) begin
                  ex_fault = 1'b1;
                  ex_setnz = 1'b0;
                  if (is_f2x && spec3[`SPEC_USED] && !spec3[`SPEC_MEM]) begin
                     ex_dr_we = 1'b1;
                     ex_dr = first_operand;
                  end else if (!(is_x2f && spec1[`SPEC_USED] && !spec1[`SPEC_MEM])) begin
                     ex_dr_we = 1'b1;
                     ex_dr = action_reg[`ACT_TNAN1] ? first_operand : second_operand;
                     ex_j = (spec3[`SPEC_FMT_HI:`SPEC_FMT_LO] != `FMT_EXT);
                  end
                  // A register-sourced integer or decimal conversion leaves the
                  // fault data as it stood.
               end else begin
                  ex_res = `QNAN_POS;
               end
            end
            `ACT_DIVZERO: begin
               ex_qs = 1'b1;
               ex_res = {act_sign, `INF_POS};
               if (auxiliary_status_reg[`ASR_QM]) begin
                  ex_fault = 1'b1;
                  ex_setnz = 1'b0;
               end
            end
            `ACT_PASS1: ex_res = first_operand;
            `ACT_ZERO: ex_res = {act_sign, 31'h0000_0000};
            `ACT_INF: ex_res = {act_sign, `INF_POS};
            `ACT_PASS2: ex_res = second_operand;
            `ACT_SIGNZERO: begin
               if (first_operand[31] == second_operand[31]) begin
                  ex_res = first_operand;
               end else if (round_toward_minus) begin
                  ex_res = `NEG_ZERO;
               end else begin
                  ex_res = 32'h0000_0000;
               end
            end
            default: ex_res = dp_result_reg;
         endcase
      end
      // Unassigned opcodes fall through here with no flag or fault change.
   end

   // -----------------------------------------------------------
   // Register read mux
   // -----------------------------------------------------------
   function [32:0] reg_value;
      input [7:0] addr;
      begin
         reg_value = {1'b1, 32'h0000_0000};
         case (addr)
            `ADDR_CMD: reg_value = {1'b1, cmd_reg};
            `ADDR_ASR: reg_value = {1'b1, auxiliary_status_reg};
            `ADDR_OP1: reg_value = {1'b1, op1_mem_reg};
            `ADDR_OP2: reg_value = {1'b1, op2_mem_reg};
            `ADDR_ACTION: reg_value = {1'b1, action_reg};
            `ADDR_DPRES: reg_value = {1'b1, dp_result_reg};
            `ADDR_RESULT: reg_value = {1'b1, result_mem_reg};
            `ADDR_FDR: reg_value = {1'b1, fault_data_register};
            `ADDR_STATUS: reg_value = {1'b1, 26'h0, state_reg, fault_reg, done_reg, busy};
            `ADDR_F0: reg_value = {1'b1, fpr[0]};
            `ADDR_F1: reg_value = {1'b1, fpr[1]};
            `ADDR_F2: reg_value = {1'b1, fpr[2]};
            `ADDR_F3: reg_value = {1'b1, fpr[3]};
            default: reg_value = {1'b0, 32'h0000_0000};
         endcase
      end
   endfunction

   wire [32:0] wr_old = reg_value(awaddr_q);
   wire [32:0] rd_val = reg_value(araddr);
   wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   wire [31:0] wr_val = (wr_old[31:0] & ~wmask) | (wdata_q & wmask);
   wire do_write = aw_full && w_full && !bvalid;
   wire [1:0] sreg_idx = awaddr_q[3:2] + 2'h3;

   // -----------------------------------------------------------
   // Bus slave, sequencer and register file
   // -----------------------------------------------------------
   // Software writes to the status, fault data and operand registers are
   // dropped while a command runs, so a hardware flag update can never be
   // lost to a coincident software write.
   always @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `RESP_OKAY;
         aw_full <= 1'b0;
         w_full <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         state_reg <= S_IDLE;
         cmd_reg <= 32'h0000_0000;
         auxiliary_status_reg <= `ASR_RESET;
         op1_mem_reg <= 32'h0000_0000;
         op2_mem_reg <= 32'h0000_0000;
         action_reg <= 32'h0000_0000;
         dp_result_reg <= 32'h0000_0000;
         result_mem_reg <= 32'h0000_0000;
         fault_data_register <= 32'h0000_0000;
         first_operand <= 32'h0000_0000;
         second_operand <= 32'h0000_0000;
         result_operand <= 32'h0000_0000;
         fpr[0] <= 32'h0000_0000;
         fpr[1] <= 32'h0000_0000;
         fpr[2] <= 32'h0000_0000;
         fpr[3] <= 32'h0000_0000;
         wide1_reg <= 1'b0;
         wide2_reg <= 1'b0;
         narrow_reg <= 1'b0;
         fault_reg <= 1'b0;
         done_reg <= 1'b0;
         done_pulse <= 1'b0;
         exception_signal <= 1'b0;
      end else begin
         done_pulse <= 1'b0;
         if (awvalid && awready) begin
            aw_full <= 1'b1;
            awaddr_q <= awaddr;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            w_full <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
            wready <= 1'b0;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
         if (do_write) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_old[32] ? `RESP_OKAY : `RESP_SLVERR;
            if (!busy) begin
               case (awaddr_q)
                  `ADDR_CMD: begin
                     cmd_reg <= wr_val;
                     state_reg <= S_FETCH1;
                     done_reg <= 1'b0;
                     fault_reg <= 1'b0;
                     exception_signal <= 1'b0;
                  end
                  `ADDR_ASR: auxiliary_status_reg <= wr_val;
                  `ADDR_OP1: op1_mem_reg <= wr_val;
                  `ADDR_OP2: op2_mem_reg <= wr_val;
                  `ADDR_ACTION: action_reg <= wr_val;
                  `ADDR_DPRES: dp_result_reg <= wr_val;
                  `ADDR_FDR: fault_data_register <= wr_val;
                  `ADDR_F0, `ADDR_F1, `ADDR_F2, `ADDR_F3: fpr[sreg_idx] <= wr_val;
                  default: cmd_reg <= cmd_reg;
               endcase
            end
         end
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_val[31:0];
            rresp <= rd_val[32] ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
         case (state_reg)
            S_IDLE: done_pulse <= 1'b0;
            S_FETCH1: begin
               // Any non-NOP specifier is read even when the opcode ignores it.
               if (spec1 != `SPEC_NOP) begin
                  first_operand <= spec1[`SPEC_MEM] ? op1_mem_reg : fpr[spec1[1:0]];
               end
               wide1_reg <= spec1[`SPEC_USED] && spec1[`SPEC_MEM];
               state_reg <= S_FETCH2;
            end
            S_FETCH2: begin
               if (spec2 != `SPEC_NOP) begin
                  second_operand <= spec2[`SPEC_MEM] ? op2_mem_reg : fpr[spec2[1:0]];
               end
               wide2_reg <= spec2[`SPEC_USED] && spec2[`SPEC_MEM];
               state_reg <= S_CONV;
            end
            S_CONV: begin
               // Operand words are held as the internal image once widened; the
               // marks set at fetch for memory operands are cleared in this step.
               wide1_reg <= 1'b0;
               wide2_reg <= 1'b0;
               state_reg <= S_EXEC;
            end
            S_EXEC: begin
               result_operand <= ex_res;
               fault_reg <= ex_fault;
               if (ex_is) begin
                  auxiliary_status_reg[`ASR_IS] <= 1'b1;
               end
               if (ex_qs) begin
                  auxiliary_status_reg[`ASR_QS] <= 1'b1;
               end
               if (ex_fault) begin
                  auxiliary_status_reg[`ASR_ECP] <= 1'b1;
                  auxiliary_status_reg[`ASR_Z] <= 1'b0;
               end
               if (ex_dr_we) begin
                  fault_data_register <= ex_dr;
                  auxiliary_status_reg[`ASR_J] <= ex_j;
               end
               if (is_cmp && !ex_fault) begin
                  auxiliary_status_reg[`ASR_N] <= cmp_swap ? action_reg[`ACT_EQUAL] :
                                                  action_reg[`ACT_LESS];
                  auxiliary_status_reg[`ASR_Z] <= cmp_swap ? action_reg[`ACT_LESS] :
                                                  action_reg[`ACT_EQUAL];
               end
               if (opcode == `OPC_WRSTAT) begin
                  auxiliary_status_reg <= first_operand;
               end
               if (opcode == `OPC_LDFD) begin
                  fault_data_register <= first_operand;
               end
               if (ex_setnz) begin
                  auxiliary_status_reg[`ASR_N] <= ex_res[31];
                  auxiliary_status_reg[`ASR_Z] <= (ex_res[30:0] == 31'h0000_0000);
               end
               state_reg <= S_NARROW;
            end
            S_NARROW: begin
               narrow_reg <= spec3[`SPEC_USED] &&
                             (spec3[`SPEC_FMT_HI:`SPEC_FMT_LO] != `FMT_EXT);
               state_reg <= S_ROUND;
            end
            S_ROUND: begin
               // Overflow and underflow can only come from narrowing the wide
               // intermediate into a single or double destination.
               if (narrow_reg && !fault_reg) begin
                  if (action_reg[`ACT_OVF]) begin
                     auxiliary_status_reg[`ASR_OVS] <= 1'b1;
                  end
                  if (action_reg[`ACT_UNF]) begin
                     auxiliary_status_reg[`ASR_UNS] <= 1'b1;
                  end
               end
               state_reg <= S_STORE;
            end
            S_STORE: begin
               if (fault_reg) begin
                  if (act_code == `ACT_DIVZERO) begin
                     fault_data_register <= result_operand;
                  end
               end else if (spec3 != `SPEC_NOP) begin
                  // An unused but named destination still receives a word.
                  if (spec3[`SPEC_MEM]) begin
                     result_mem_reg <= result_operand;
                  end else begin
                     fpr[spec3[1:0]] <= result_operand;
                  end
               end
               exception_signal <= fault_reg;
               done_reg <= 1'b1;
               done_pulse <= 1'b1;
               state_reg <= S_IDLE;
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end
endmodule // fp_coprocessor_opcode_dispatch

// File: core/fp_dispatch_defs.vh
`ifndef FP_DISPATCH_DEFS_VH
`define FP_DISPATCH_DEFS_VH
// Opcodes.
`define OPC_ADD 8'h02
`define OPC_SUB 8'h03
`define OPC_DIV 8'h04
`define OPC_REM 8'h05
`define OPC_MUL 8'h06
`define OPC_MOVE 8'h07
`define OPC_RDSTAT 8'h08
`define OPC_WRSTAT 8'h09
`define OPC_CMP 8'h0A
`define OPC_CMPX 8'h0B
`define OPC_ABS 8'h0C
`define OPC_SQUARE_ROOT_OP 8'h0D
`define OPC_RINT 8'h0E
`define OPC_F2I 8'h0F
`define OPC_I2F 8'h10
`define OPC_D2F 8'h11
`define OPC_F2D 8'h12
`define OPC_NOP 8'h13
`define OPC_EXTR 8'h14
`define OPC_NEG 8'h17
`define OPC_LDFD 8'h18
`define OPC_COMPARE_SWAPPED_OP 8'h1A
`define OPC_CMPXS 8'h1B
// Register byte offsets.
`define ADDR_CMD 8'h00
`define ADDR_ASR 8'h04
`define ADDR_OP1 8'h08
`define ADDR_OP2 8'h0C
`define ADDR_ACTION 8'h10
`define ADDR_DPRES 8'h14
`define ADDR_RESULT 8'h18
`define ADDR_FDR 8'h1C
`define ADDR_STATUS 8'h20
`define ADDR_F0 8'h24
`define ADDR_F1 8'h28
`define ADDR_F2 8'h2C
`define ADDR_F3 8'h30
// Operand specifier layout.
`define SPEC_NOP 8'h00
`define SPEC_USED 7
`define SPEC_FMT_HI 4
`define SPEC_FMT_LO 3
`define SPEC_MEM 2
`define FMT_EXT 2'h2
// Auxiliary status bit positions.
`define ASR_N 0
`define ASR_Z 1
`define ASR_IS 2
`define ASR_QS 3
`define ASR_IM 4
`define ASR_QM 5
`define ASR_NONTRAPPING_NAN_CONTROL 6
`define ASR_ECP 7
`define ASR_RC_LO 8
`define ASR_RC_HI 9
`define ASR_J 10
`define ASR_OVS 11
`define ASR_UNS 12
`define ASR_RESET 32'h0000_0000
`define RC_MINUS 2'h3
// Action register fields.
`define ACT_CODE_HI 3
`define ACT_TNAN1 4
`define ACT_SIGN 5
`define ACT_LESS 6
`define ACT_EQUAL 7
`define ACT_OVF 8
`define ACT_UNF 9
// Action codes.
`define ACT_INVALID 4'h1
`define ACT_DIVZERO 4'h2
`define ACT_PASS1 4'h3
`define ACT_ZERO 4'h4
`define ACT_INF 4'h5
`define ACT_PASS2 4'h6
`define ACT_SIGNZERO 4'h7
// Value images and bus answers.
`define QNAN_POS 32'h7FC0_0000
`define INF_POS 31'h7F80_0000
`define NEG_ZERO 32'h8000_0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: tb/fp_coprocessor_opcode_dispatch_tb.sv
`timescale 1ns/10ps
`include "fp_dispatch_defs.vh"
module fp_coprocessor_opcode_dispatch_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready, done_pulse, exception_signal;
   logic arvalid, arready, rvalid, rready;
   int num_errors = 0;
   int checks_done = 0;
   localparam logic [23:0] SP = {8'h92, 8'h91, 8'h90};
   always #12.5 aclk = ~aclk;
   fp_coprocessor_opcode_dispatch fp_coprocessor_opcode_dispatch_i (.*);
   fp_host_model fp_host_model_i (.*);
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      fp_host_model_i.wr(a, d, r);
      chk(r, a > `ADDR_F3 ? `RESP_SLVERR : `RESP_OKAY, "bresp");
   endtask
   task rdv(input logic [7:0] a, output logic [31:0] d);
      logic [1:0] r;
      fp_host_model_i.rd(a, d, r);
      chk(r, a > `ADDR_F3 ? `RESP_SLVERR : `RESP_OKAY, "rresp");
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] d;
      rdv(a, d);
      chk(d, exp, what);
   endtask
   task run(input logic [7:0] opc, input logic [31:0] act, input logic [31:0] dp,
         input logic [23:0] sp, input logic exc);
      int n;
      wr(`ADDR_ACTION, act);
      wr(`ADDR_DPRES, dp);
      wr(`ADDR_CMD, {sp, opc});
      n = 0;
      while (done_pulse !== 1'b1 && n < 20) begin
         @(posedge aclk);
         #1;
         n++;
      end
      chk({n < 20, exception_signal}, {1'b1, exc}, "completion");
   endtask
   function logic [31:0] exp_res(input logic [3:0] c, input logic [31:0] a,
         input logic [31:0] b, input logic s, input logic [1:0] rc);
      case (c)
         `ACT_PASS1: return a;
         `ACT_ZERO: return {s, 31'h0000_0000};
         `ACT_INF: return {s, 31'h7F80_0000};
         `ACT_PASS2: return b;
         default: return a[31] == b[31] ? a : rc == `RC_MINUS ? `NEG_ZERO : 32'h0000_0000;
      endcase
   endfunction
   task finish_test;
      if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      $display("MISMATCH %0t timeout", $time);
      finish_test();
   end
   initial begin
      logic [31:0] a, b, d, base;
      logic [7:0] ops [14] = '{`OPC_ADD, `OPC_SUB, `OPC_DIV, `OPC_REM, `OPC_MUL, `OPC_MOVE,
         `OPC_ABS, `OPC_SQUARE_ROOT_OP, `OPC_RINT, `OPC_NEG, `OPC_F2I, `OPC_I2F, `OPC_D2F, `OPC_F2D};
      logic [7:0] compare_swapped_op [4] = '{`OPC_CMP, `OPC_CMPX, `OPC_COMPARE_SWAPPED_OP, `OPC_CMPXS};
      logic [7:0] nops [6] = '{`OPC_NOP, 8'h00, 8'h01, 8'h15, 8'h1C, 8'hFF};
      logic [3:0] c;
      logic s, t;
      a = $urandom(32'h3112);
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(`ADDR_ASR, `ASR_RESET, "status reset");
      rdc(8'h40, 32'h0000_0000, "unmapped");
      wr(`ADDR_RESULT, 32'h1234_5678);
      rdc(`ADDR_RESULT, 32'h0000_0000, "read-only result");
      foreach (ops[i]) begin
         d = i == 0 ? 32'h8000_0000 : $urandom();
         run(ops[i], 32'h0000_0008, d, SP, 1'b0);
         rdc(`ADDR_F2, d, "result");
         rdc(`ADDR_ASR, {30'h0, d[30:0] == 0, d[31]}, "flags");
      end
      foreach (compare_swapped_op[i]) begin
         s = $urandom();
         t = !s && $urandom();
         run(compare_swapped_op[i], {24'h0, t, s, 6'h00}, 32'h0, SP, 1'b0);
         rdv(`ADDR_ASR, d);
         chk(d[1:0], i < 2 ? {t, s} : {s, t}, "compare flags");
      end
      wr(`ADDR_ASR, 32'h0000_0013);
      wr(`ADDR_F2, 32'h0BAD_0001);
      foreach (nops[i]) begin
         run(nops[i], 32'h0000_0001, 32'h0, {8'h00, 8'h91, 8'h90}, 1'b0);
         rdc(`ADDR_ASR, 32'h0000_0013, "idle flags");
      end
      rdc(`ADDR_F2, 32'h0BAD_0001, "idle destination");
      for (int k = 0; k < 5; k++) begin
         base = k == 4 ? 32'h0000_0003 : k % 2 ? 32'h0000_0043 : 32'h0000_0013;
         d = k == 2 ? `OPC_F2I : k == 3 ? `OPC_I2F : `OPC_ADD;
         a = $urandom();
         b = $urandom();
         t = $urandom();
         wr(`ADDR_ASR, base);
         wr(`ADDR_FDR, 32'h0000_0000);
         wr(`ADDR_F0, a);
         wr(`ADDR_F1, b);
         wr(`ADDR_F2, 32'h0BAD_0002);
         run(d[7:0], {27'h0, t, 4'h1}, 32'h0, SP, k < 4);
         rdc(`ADDR_ASR, k < 4 ? base & ~32'h2 | 32'h84 : 32'h4, "invalid flags");
         rdc(`ADDR_FDR, k == 2 ? a : k < 2 ? (t ? a : b) : 32'h0, "fault data");
         rdc(`ADDR_F2, k < 4 ? 32'h0BAD_0002 : `QNAN_POS, "invalid result");
      end
      for (int k = 0; k < 2; k++) begin
         s = $urandom();
         wr(`ADDR_ASR, k ? 32'h0000_0020 : 32'h0000_0000);
         run(`OPC_DIV, {26'h0, s, 5'h02}, 32'h0, SP, k);
         rdv(`ADDR_ASR, d);
         chk(d[3:0], k ? 4'h8 : {3'h4, s}, "divide flags");
         rdc(k ? `ADDR_FDR : `ADDR_F2, {s, 31'h7F80_0000}, "infinity");
      end
      for (int i = 0; i < 20; i++) begin
         c = 4'h3 + i % 5;
         a = $urandom();
         b = $urandom();
         b[31] = i % 2 ? a[31] : b[31];
         s = $urandom();
         d = $urandom() & 32'h0000_0300;
         wr(`ADDR_ASR, d);
         wr(`ADDR_F0, a);
         wr(`ADDR_F1, b);
         run(`OPC_ADD, {26'h0, s, 1'b0, c}, $urandom(), SP, 1'b0);
         rdc(`ADDR_F2, exp_res(c, a, b, s, d[9:8]), "action");
      end
      for (int j = 0; j < 2; j++) begin
         wr(`ADDR_ASR, 32'h0000_0000);
         run(`OPC_MUL, 32'h100 << j | 32'h8, $urandom(), {8'h82, 8'h91, 8'h90}, 1'b0);
         rdv(`ADDR_ASR, d);
         chk(d[12:11], 2'h1 << j, "narrowing flags");
      end
      a = $urandom();
      wr(`ADDR_OP1, a);
      wr(`ADDR_F0, a);
      wr(`ADDR_F1, ~a);
      run(`OPC_WRSTAT, 32'h0, 32'h0, 24'h91, 1'b0);
      run(`OPC_LDFD, 32'h0, 32'h0, 24'h90, 1'b0);
      run(`OPC_RDSTAT, 32'h0, 32'h0, SP, 1'b0);
      rdc(`ADDR_F2, ~a, "status read");
      run(`OPC_EXTR, 32'h0, 32'h0, 24'h920091, 1'b0);
      rdc(`ADDR_F2, a, "fault extract");
      run(`OPC_MOVE, 32'h0000_0003, 32'h0, {8'h94, 8'h00, 8'h94}, 1'b0);
      rdc(`ADDR_RESULT, a, "memory result");
      finish_test();
   end
endmodule // fp_coprocessor_opcode_dispatch_tb

// File: tb/fp_dispatch_assertions.sv
`timescale 1ns/10ps
`include "fp_dispatch_defs.vh"
module fp_dispatch_assertions (
   // Clock and reset.
   input wire aclk,
   input wire aresetn,
   // Write channels.
   input wire [7:0] awaddr,
   input wire awvalid,
   input wire awready,
   input wire wvalid,
   input wire wready,
   input wire bvalid,
   // Read channels.
   input wire [7:0] araddr,
   input wire arvalid,
   input wire arready,
   input wire [31:0] rdata,
   input wire [1:0] rresp,
   input wire rvalid,
   // Completion.
   input wire done_pulse,
   input wire exception_signal
);
   reg [7:0] aw_addr_reg;
   reg pend_reg;
   wire start;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // A command write while one runs is dropped and starts nothing.
   assign start = bvalid && !pend_reg && aw_addr_reg == `ADDR_CMD;
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_reg <= 8'hFF;
         pend_reg <= 1'b0;
      end else begin
         if (awvalid && awready) aw_addr_reg <= awaddr;
         if (start) pend_reg <= 1'b1;
         else if (done_pulse) pend_reg <= 1'b0;
      end
   end
   wr_answer_a: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
      else $error("write not answered");
   ready_low_a: assert property (bvalid |-> !awready && !wready)
      else $error("write ready during response");
   rd_answer_a: assert property (arvalid && arready |=> rvalid)
      else $error("read not answered");
   rd_busy_a: assert property (rvalid |-> !arready)
      else $error("read ready during response");
   unmapped_rd_a: assert property (arvalid && arready && araddr > `ADDR_F3
      |=> rresp == `RESP_SLVERR && rdata == 32'h0000_0000) else $error("unmapped read");
   cmd_done_a: assert property (start |-> ##7 done_pulse)
      else $error("command completion late");
   done_once_a: assert property (done_pulse |-> pend_reg ##1 !done_pulse)
      else $error("stray completion pulse");
   exc_at_done_a: assert property ($rose(exception_signal) |-> done_pulse)
      else $error("stray exception");
endmodule // fp_dispatch_assertions
bind fp_coprocessor_opcode_dispatch fp_dispatch_assertions fp_dispatch_assertions_i (.*);

// File: tb/fp_host_model.sv
`timescale 1ns/10ps
module fp_host_model (
   // Clock.
   input wire aclk,
   // Write channels.
   output logic [7:0] awaddr = 8'h00,
   output logic awvalid = 1'b0,
   input wire awready,
   output logic [31:0] wdata = 32'h0000_0000,
   output logic [3:0] wstrb = 4'hF,
   output logic wvalid = 1'b0,
   input wire wready,
   input wire [1:0] bresp,
   input wire bvalid,
   output logic bready = 1'b0,
   // Read channels.
   output logic [7:0] araddr = 8'h00,
   output logic arvalid = 1'b0,
   input wire arready,
   input wire [31:0] rdata,
   input wire [1:0] rresp,
   input wire rvalid,
   output logic rready = 1'b0
);
   // Each request starts one edge later, so no strobe falls and rises in one time step.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule // fp_host_model
